// ===== rtl/pia_pkg.sv
/*
 * Package for the priority interrupt arbiter: register indices, field
 * layout, reset values, source counts and the carrier structs.
 * Assumes nothing of its surroundings.
 */
package pia_pkg;

  localparam int NUM_SRC = 16;
  localparam int NUM_PIN = 6;
  localparam int LVL_W = 4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int SRC_W = 4;

  // Register indices; priority registers a..h at 0..7
  localparam logic [ADDR_W-1:0] PRIO_A_IDX = 4'h0;
  localparam logic [ADDR_W-1:0] PRIO_H_IDX = 4'h7;
  localparam logic [ADDR_W-1:0] SENSE_IDX = 4'h8;
  localparam logic [ADDR_W-1:0] PIN_STAT_IDX = 4'h9;
  localparam logic [ADDR_W-1:0] DMA_CTRL_IDX = 4'ha;
  localparam logic [ADDR_W-1:0] DMA_SEL_IDX = 4'hb;
  localparam logic [ADDR_W-1:0] ACC_IDX = 4'hc;

  localparam logic [DATA_W-1:0] PRIO_RESET = 16'h0000;
  localparam logic [LVL_W-1:0] LVL_LOW = 4'h0;

  // Control register bit positions
  localparam int DME_BIT = 0;
  localparam int DE0_BIT = 1;
  localparam int DE1_BIT = 2;

  // Acceptance status layout: valid, source, level
  localparam int ACC_VALID_BIT = 15;
  localparam int ACC_SRC_LSB = 4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } pia_bus_req_t;

  typedef struct packed {
    logic req;
    logic [LVL_W-1:0] level;
    logic [SRC_W-1:0] src;
  } pia_cpu_req_t;

endpackage : pia_pkg

// ===== rtl/pia_arbiter.sv
/*
 * Priority interrupt arbiter: pin and peripheral requests, per-source
 * 4-bit levels, fixed tie order, mask compare, dma diversion.
 * Assumes a cpu that takes the request while decoding, acknowledges it
 * with a one-cycle pulse and loads the level into its own mask; peripheral
 * requests are levels held by their modules until cleared.
 */
// Added by the designer: the address-and-strobe port and the address map.
//
// Function
// RQ1: Pick the pending request with the highest programmed level.
// RQ2: Edge-sensed pin requests stay latched until accepted.
// RQ3: Power-on reset clears every latched edge request.
// RQ4: Equal levels resolve by fixed order, lower source index wins.
// RQ5: Ignore selection when its level is at or below cpu mask.
// RQ6: Level above cpu mask raises the request output to the cpu.
// RQ7: Cpu samples the request on decode and enters exception processing.
// RQ8: Cpu pushes status and program counter before vector fetch.
// RQ9: Accepted level is driven out for the cpu mask field.
// RQ10: Cpu jumps to the vector table entry, no delay slot.
// RQ11: Cpu takes five states plus three longword accesses to handler.
// RQ12: Response is seven or nine states plus three access times.
// RQ13: Acceptance may wait for the cpu's current sequence.
// RQ14: Dma sources masked: enable and (ch0 and sel0, or ch1).
// RQ15: Dma-routed source never interrupts the cpu, whatever its level.
// RQ16: Dma transfer clears the request of a dma-routed source. Code only pulses DMA_CLEAR_O; a latched pin flag stays set.
// RQ17: Otherwise the request goes through normal arbitration.
// RQ18: Software withdraws a pending pin request via pin status.
// RQ19: Level fields: 0 lowest, 15 highest, reset to zero.
// RQ20: Edge flag clears on writing 0 after reading it as 1.
// RQ21: Edge flag clears once its exception processing ran.
// RQ22: Arbitration result registered, held stable until acknowledged.
`timescale 1ns/1ps
`default_nettype none

module pia_arbiter
  import pia_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [pia_pkg::NUM_PIN-1:0] PIN_REQ_N_I,
  input wire logic [pia_pkg::NUM_SRC-1:0] PERIPH_REQ_I,
  input wire logic [pia_pkg::LVL_W-1:0] CPU_MASK_LEVEL_I,
  input wire logic CPU_ACK_I,
  input wire logic DMA_XFER_I,
  input wire pia_pkg::pia_bus_req_t BUS_I,
  output logic [pia_pkg::DATA_W-1:0] BUS_RDATA_O,
  output pia_pkg::pia_cpu_req_t CPU_REQ_O,
  output logic DMA_REQ_O,
  output logic [pia_pkg::NUM_SRC-1:0] DMA_CLEAR_O
);
  import pia_pkg::*;

  localparam int NREG = 8;
  initial begin
    if (NUM_PIN > NUM_SRC || NUM_SRC != NREG * 2 || LVL_W != 4) begin
      $error("pia_arbiter: unsupported source or level configuration");
    end
  end

  // Pin synchroniser, two flops
  logic [NUM_PIN-1:0] pin_s1_q;
  logic [NUM_PIN-1:0] pin_s2_q;
  logic [NUM_PIN-1:0] pin_prev_q;
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pin_s1_q <= '1;
      pin_s2_q <= '1;
      pin_prev_q <= '1;
    end else begin
      pin_s1_q <= PIN_REQ_N_I;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // Registers
  logic [DATA_W-1:0] prio_q [NREG];
  logic [NUM_PIN-1:0] sense_q;
  logic [NUM_PIN-1:0] flag_q;
  logic [NUM_PIN-1:0] flag_d;
  logic [NUM_PIN-1:0] read_one_q;
  logic [NUM_PIN-1:0] read_one_d;
  logic [2:0] dma_ctrl_q;
  logic [NUM_SRC-1:0] dma_sel_q;
  logic [DATA_W-1:0] rdata_q;
  pia_cpu_req_t cpu_q;
  logic dma_req_q;
  logic [NUM_SRC-1:0] dma_clr_q;

  wire wr_prio = BUS_I.wr && (BUS_I.addr <= PRIO_H_IDX);
  wire wr_sense = BUS_I.wr && (BUS_I.addr == SENSE_IDX);
  wire wr_stat = BUS_I.wr && (BUS_I.addr == PIN_STAT_IDX);
  wire wr_dctl = BUS_I.wr && (BUS_I.addr == DMA_CTRL_IDX);
  wire wr_dsel = BUS_I.wr && (BUS_I.addr == DMA_SEL_IDX);
  wire rd_stat = BUS_I.rd && (BUS_I.addr == PIN_STAT_IDX);
  wire [2:0] prio_idx = BUS_I.addr[2:0];

  // Per-source level, four fields per register, high nibble first
  logic [LVL_W-1:0] level [NUM_SRC];
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_lvl
    assign level[s] = prio_q[s/4][DATA_W-1-(s%4)*LVL_W -: LVL_W];
  end

  // Pin request state
  wire [NUM_PIN-1:0] pin_low = ~pin_s2_q;
  wire [NUM_PIN-1:0] pin_fall = pin_prev_q & ~pin_s2_q;
  wire ack_pin = CPU_ACK_I && cpu_q.req && (cpu_q.src < SRC_W'(NUM_PIN));

  always_comb begin
    flag_d = flag_q;
    read_one_d = read_one_q;
    for (int p = 0; p < NUM_PIN; p++) begin
      if (!sense_q[p]) begin
        flag_d[p] = pin_low[p];
      end else begin
        if (rd_stat && flag_q[p]) begin
          read_one_d[p] = 1'b1;
        end
        if (wr_stat && !BUS_I.wdata[p] && read_one_q[p]) begin
          flag_d[p] = 1'b0; // RQ18 RQ20
          read_one_d[p] = 1'b0;
        end
        if (ack_pin && cpu_q.src == SRC_W'(p)) begin
          flag_d[p] = 1'b0; // RQ21
        end
        if (pin_fall[p]) begin
          flag_d[p] = 1'b1; // RQ2
        end
      end
    end
  end

  // Request vector: pins in low sources, peripherals above
  logic [NUM_SRC-1:0] raw_req;
  always_comb begin
    raw_req = PERIPH_REQ_I;
    raw_req[NUM_PIN-1:0] = flag_q;
  end

  // Dma diversion: select bit 0 means channel-0 source
  wire dma_master_enable = dma_ctrl_q[DME_BIT];
  wire [NUM_SRC-1:0] dma_mask;
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_dma
    assign dma_mask[s] = dma_master_enable && dma_sel_q[s] &&
      ((dma_ctrl_q[DE0_BIT] && s == 0) || dma_ctrl_q[DE1_BIT]); // RQ14
  end
  wire [NUM_SRC-1:0] cpu_req_vec = raw_req & ~dma_mask; // RQ15 RQ17
  wire [NUM_SRC-1:0] dma_req_vec = raw_req & dma_mask;

  // Arbitration, strictly greater so lower index keeps ties
  logic [LVL_W-1:0] best_lvl;
  logic [SRC_W-1:0] best_src;
  logic best_vld;
  always_comb begin
    best_lvl = LVL_LOW;
    best_src = '0;
    best_vld = 1'b0;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (cpu_req_vec[s] && (!best_vld || level[s] > best_lvl)) begin
        best_vld = 1'b1; // RQ1 RQ4
        best_lvl = level[s];
        best_src = SRC_W'(s);
      end
    end
  end
  wire accept = best_vld && (best_lvl > CPU_MASK_LEVEL_I); // RQ5 RQ6

  // Read mux
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (BUS_I.addr <= PRIO_H_IDX) begin
      rd_mux = prio_q[prio_idx];
    end else if (BUS_I.addr == SENSE_IDX) begin
      rd_mux[NUM_PIN-1:0] = sense_q;
    end else if (BUS_I.addr == PIN_STAT_IDX) begin
      rd_mux[NUM_PIN-1:0] = flag_q;
    end else if (BUS_I.addr == DMA_CTRL_IDX) begin
      rd_mux[2:0] = dma_ctrl_q;
    end else if (BUS_I.addr == DMA_SEL_IDX) begin
      rd_mux = dma_sel_q;
    end else if (BUS_I.addr == ACC_IDX) begin
      rd_mux[ACC_VALID_BIT] = cpu_q.req;
      rd_mux[ACC_SRC_LSB +: SRC_W] = cpu_q.src;
      rd_mux[LVL_W-1:0] = cpu_q.level;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      for (int r = 0; r < NREG; r++) begin
        prio_q[r] <= PRIO_RESET; // RQ19
      end
    end else if (wr_prio) begin
      prio_q[prio_idx] <= BUS_I.wdata;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      sense_q <= '0;
      flag_q <= '0; // RQ3
      read_one_q <= '0;
      dma_ctrl_q <= '0;
      dma_sel_q <= '0;
      rdata_q <= '0;
    end else begin
      if (wr_sense) begin
        sense_q <= BUS_I.wdata[NUM_PIN-1:0];
      end
      if (wr_dctl) begin
        dma_ctrl_q <= BUS_I.wdata[2:0];
      end
      if (wr_dsel) begin
        dma_sel_q <= BUS_I.wdata;
      end
      flag_q <= flag_d;
      read_one_q <= read_one_d;
      rdata_q <= BUS_I.rd ? rd_mux : '0;
    end
  end

  // Cpu request held until acknowledged, then re-arbitrated
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      cpu_q <= '0;
    end else if (!cpu_q.req || CPU_ACK_I) begin
      cpu_q.req <= accept && !CPU_ACK_I; // RQ22 RQ12
      cpu_q.level <= best_lvl; // RQ9
      cpu_q.src <= best_src;
    end
  end

  // Dma side: one-cycle clear pulse per served source
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      dma_req_q <= 1'b0;
      dma_clr_q <= '0;
    end else begin
      dma_req_q <= |dma_req_vec;
      dma_clr_q <= DMA_XFER_I ? dma_req_vec : '0; // RQ16
    end
  end

  assign BUS_RDATA_O = rdata_q;
  assign CPU_REQ_O = cpu_q;
  assign DMA_REQ_O = dma_req_q;
  assign DMA_CLEAR_O = dma_clr_q;

endmodule : pia_arbiter

`default_nettype wire

// ===== test/pia_arbiter_assertions.sv
/* Checker on the arbiter ports.
   Assumes the cpu model acks only a held request. */
`timescale 1ns/1ps
`default_nettype none
module pia_arbiter_chk
  import pia_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [pia_pkg::LVL_W-1:0] CPU_MASK_LEVEL_I,
  input wire logic CPU_ACK_I,
  input wire logic DMA_XFER_I,
  input wire pia_pkg::pia_cpu_req_t CPU_REQ_O,
  input wire logic [pia_pkg::NUM_SRC-1:0] DMA_CLEAR_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  a_rise_above_mask: assert property ($rose(CPU_REQ_O.req) |->
    CPU_REQ_O.level > $past(CPU_MASK_LEVEL_I)) else $error("low req");
  a_req_held: assert property (CPU_REQ_O.req && !CPU_ACK_I |=>
    CPU_REQ_O.req && $stable(CPU_REQ_O)) else $error("req moved");
  a_ack_drops_req: assert property (CPU_REQ_O.req && CPU_ACK_I |=>
    !CPU_REQ_O.req) else $error("req kept after ack");
  a_clear_cause: assert property (DMA_CLEAR_O != '0 |->
    $past(DMA_XFER_I)) else $error("clear without transfer");
  a_clear_single: assert property (DMA_CLEAR_O != '0 && !DMA_XFER_I
    |=> DMA_CLEAR_O == '0) else $error("clear too long");
  a_dma_no_cpu: assert property (CPU_REQ_O.req |->
    !DMA_CLEAR_O[CPU_REQ_O.src]) else $error("dma source at cpu");
  a_level_nonzero: assert property (CPU_REQ_O.req |->
    CPU_REQ_O.level != '0) else $error("level zero req");
  a_reset_quiet: assert property ($fell(RST_I) |->
    !CPU_REQ_O.req && DMA_CLEAR_O == '0) else $error("busy after reset");
  cover property (CPU_REQ_O.req && CPU_ACK_I);
  cover property (DMA_CLEAR_O != '0);
  cover property ($rose(CPU_REQ_O.req));
endmodule : pia_arbiter_chk
bind pia_arbiter pia_arbiter_chk chk_u (.CLK_SYS_I(CLK_SYS_I),
  .RST_I(RST_I), .CPU_MASK_LEVEL_I(CPU_MASK_LEVEL_I),
  .CPU_ACK_I(CPU_ACK_I), .DMA_XFER_I(DMA_XFER_I),
  .CPU_REQ_O(CPU_REQ_O), .DMA_CLEAR_O(DMA_CLEAR_O));
`default_nettype wire

// ===== test/pia_cpu_model.sv
/* Cpu side: acks a held request when let go, loads its mask.
   Assumes the arbiter holds its request until ack. */
`timescale 1ns/1ps
`default_nettype none
module pia_cpu_model
  import pia_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pia_pkg::pia_cpu_req_t req_i,
  input wire logic go_i,
  input wire logic ld_i,
  input wire logic [pia_pkg::LVL_W-1:0] lvl_i,
  output logic ack_o,
  output logic [pia_pkg::LVL_W-1:0] mask_o
);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      mask_o <= 4'hf;
    end else begin
      ack_o <= req_i.req && go_i && !ack_o;
      if (ld_i) begin
        mask_o <= lvl_i;
      end else if (ack_o) begin
        // Saves, vector read and handler fetch abstracted to this load
        mask_o <= req_i.level;
      end
    end
  end
endmodule : pia_cpu_model
`default_nettype wire

// ===== test/tb_priority_interrupt_arbiter.sv
/* Bench: bus tasks and scripted cases.
   Assumes the arbiter, its checker and the cpu model. */
`timescale 1ns/1ps
`default_nettype none
module tb_priority_interrupt_arbiter;
  import pia_pkg::*;
  logic clk = 0, rst = 1, ack, go = 0, ld = 0, xfer = 0, dreq;
  logic [5:0] pin_n = 6'h3f;
  logic [15:0] per = 16'h0000, v, rdata, dclr;
  logic [3:0] lvl = 4'h0, mask;
  pia_bus_req_t bus = '0;
  pia_cpu_req_t creq;
  int n_errors = 0, check_count = 0;
  initial forever #12.5 clk = ~clk;
  pia_arbiter dut_u (.CLK_SYS_I(clk), .RST_I(rst), .PIN_REQ_N_I(pin_n),
    .PERIPH_REQ_I(per), .CPU_MASK_LEVEL_I(mask), .CPU_ACK_I(ack),
    .DMA_XFER_I(xfer), .BUS_I(bus), .BUS_RDATA_O(rdata),
    .CPU_REQ_O(creq), .DMA_REQ_O(dreq), .DMA_CLEAR_O(dclr));
  pia_cpu_model cpu_u (.clk_i(clk), .rst_i(rst), .req_i(creq), .go_i(go),
    .ld_i(ld), .lvl_i(lvl), .ack_o(ack), .mask_o(mask));
  task automatic chk(input string nm, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 v = rdata;
  endtask : rd
  task automatic setm(input logic [3:0] m);
    @(posedge clk);
    ld <= 1'b1;
    lvl <= m;
    @(posedge clk);
    ld <= 1'b0;
  endtask : setm
  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 0) go <= 1'b1;
    else if (k == 1) xfer <= 1'b1;
    else pin_n <= 6'h3e;
    cyc(2 - k % 2);
    {go, xfer, pin_n} <= {2'b00, 6'h3f};
  endtask : pulse
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    #50000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    cyc(3);
    rst <= 1'b0;
    for (int r = 0; r < 8; r++) begin
      rd(r[3:0]);
      chk("prio", PRIO_RESET, v);
    end
    rd(PIN_STAT_IDX);
    chk("flags", 16'h0000, v);
    rd(4'hd);
    chk("unmapped", 16'h0000, v);
    setm(4'h2);
    wr(4'h2, 16'h5500);
    wr(4'h3, 16'h7000);
    per <= 16'h0300;
    cyc(2);
    rd(ACC_IDX);
    chk("tie", 16'h8085, v);
    per <= 16'h1300;
    cyc(3);
    rd(ACC_IDX);
    chk("held", 16'h8085, v);
    pulse(0);
    cyc(3);
    rd(ACC_IDX);
    chk("next", 16'h80c7, v);
    pulse(0);
    cyc(3);
    rd(ACC_IDX);
    chk("masked", 16'h0000, v & 16'h8000);
    per <= 16'h0000;
    wr(DMA_CTRL_IDX, 16'h0005);
    wr(DMA_SEL_IDX, 16'h0400);
    wr(4'h2, 16'h00f0);
    setm(4'h0);
    per <= 16'h0400;
    cyc(3);
    chk("dreq", 16'h0001, {15'h0, dreq});
    chk("dcpu", 16'h0000, {15'h0, creq.req});
    pulse(1);
    #1 chk("dclr", 16'h0400, dclr);
    per <= 16'h0000;
    wr(DMA_CTRL_IDX, 16'h0000);
    per <= 16'h0400;
    cyc(3);
    rd(ACC_IDX);
    chk("nodma", 16'h80af, v);
    pulse(0);
    per <= 16'h0000;
    wr(SENSE_IDX, 16'h0001);
    wr(4'h0, 16'h9000);
    pulse(2);
    cyc(5);
    rd(PIN_STAT_IDX);
    chk("edge", 16'h0001, v);
    wr(PIN_STAT_IDX, 16'h0000);
    rd(PIN_STAT_IDX);
    chk("withdraw", 16'h0000, v);
    pulse(2);
    setm(4'h0);
    cyc(4);
    rd(ACC_IDX);
    chk("pin", 16'h8009, v);
    pulse(0);
    cyc(2);
    rd(PIN_STAT_IDX);
    chk("ackclr", 16'h0000, v);
    wr(SENSE_IDX, 16'h0000);
    pin_n <= 6'h3e;
    cyc(5);
    rd(PIN_STAT_IDX);
    chk("lvlon", 16'h0001, v);
    pin_n <= 6'h3f;
    cyc(4);
    rd(PIN_STAT_IDX);
    chk("lvloff", 16'h0000, v);
    tally_and_finish();
  end
endmodule : tb_priority_interrupt_arbiter
`default_nettype wire
